// file: rtl/mpc_ctrl.sv
// PHY control state block: reset, standby, transmit, receive, sleep and wake.
// Assumes link pins are asynchronous to core_clk; sleep request and air status are core_clk logic.
// Function
// - Data path is a byte bus whose mode follows the PHY operating state.
// - MAC sets state via control group; PHY reports transmit and receive status there.
// - Internal registers reachable only through the management group.
// - Reset held low clears all PHY variables and returns to initial condition.
// - After reset release and internal work, load standby code, then enter standby.
// - Reset input accepted with no relation to either interface clock.
// - Reset input is active low.
// - Transmit enable asserted moves the PHY to transmit.
// - Receive enable asserted moves the PHY to receive.
// - In sleep, both enables high request standby; PHY then enters standby.
// - Transmit enable follows MAC clock outside sleep, unclocked in sleep.
// - Receive enable follows MAC clock outside sleep, unclocked in sleep.
// - Transmit enable is active high.
// - Receive enable is active high.
// - PHY never relies on MAC clock running when enables toggle.
// - Air activity flag takes part in leaving sleep and leaving reset.
`timescale 1ns/1ns
`default_nettype none
`include "mpc_consts.svh"

module mpc_ctrl (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Control group from the MAC
   input wire logic link_reset_n,
   input wire logic tx_en,
   input wire logic rx_en,
   // Core side
   input wire logic sleep_req,
   input wire logic air_busy,
   // Status back to the MAC
   output logic air_activity_flag,
   output logic tx_active,
   output logic rx_active,
   // Data bus mode
   output logic data_bus_tx_mode,
   output logic data_bus_rx_mode,
   // Management group view
   output mpc_pkg::mpc_pm_type power_mode_field,
   output mpc_pkg::mpc_state_type phy_state
);
   import mpc_pkg::*;

   localparam int RESET_N = `MPC_RESET_WORK_CYC;
   localparam int WAKE_N = `MPC_WAKE_WORK_CYC;

   mpc_sync_if sif ();

   mpc_sync u_sync (
      .core_clk(core_clk),
      .srst(srst),
      .sif(sif)
   );

   // No MAC clock is used: pins are sampled by core_clk only
   assign sif.raw[`MPC_SYNC_LRST] = link_reset_n;
   assign sif.raw[`MPC_SYNC_TXEN] = tx_en;
   assign sif.raw[`MPC_SYNC_RXEN] = rx_en;

   logic rst_req;
   logic tx_req;
   logic rx_req;
   assign rst_req = !sif.synced[`MPC_SYNC_LRST];
   assign tx_req = sif.synced[`MPC_SYNC_TXEN];
   assign rx_req = sif.synced[`MPC_SYNC_RXEN];

   mpc_state_type state_reg;
   mpc_state_type state_next;
   mpc_cnt_type cnt_reg;
   mpc_cnt_type cnt_next;
   mpc_pm_type pm_reg;
   mpc_pm_type pm_next;
   logic act_reg;
   logic act_next;

   function automatic logic cnt_done(input mpc_cnt_type cnt, input int limit);
      cnt_done = (cnt == mpc_cnt_type'(limit - 1));
   endfunction

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      pm_next = pm_reg;
      act_next = act_reg;
      case (state_reg)
         MPC_ST_RESET: begin
            // Flag high while reset work runs after release
            act_next = !rst_req;
            if (rst_req) begin
               cnt_next = `MPC_CNT_ZERO;
            end else if (cnt_done(cnt_reg, RESET_N)) begin
               pm_next = `MPC_PM_STANDBY;
               state_next = MPC_ST_STANDBY;
               cnt_next = `MPC_CNT_ZERO;
               act_next = 1'b0;
            end else begin
               cnt_next = cnt_reg + `MPC_CNT_ONE;
            end
         end
         MPC_ST_STANDBY: begin
            act_next = 1'b0;
            // Both high is a wake request only; ignored outside sleep
            if (tx_req && !rx_req) begin
               state_next = MPC_ST_TRANSMIT;
               pm_next = `MPC_PM_TRANSMIT;
            end else if (rx_req && !tx_req) begin
               state_next = MPC_ST_RECEIVE;
               pm_next = `MPC_PM_RECEIVE;
            end else if (sleep_req && !tx_req && !rx_req) begin
               state_next = MPC_ST_SLEEP;
               pm_next = `MPC_PM_SLEEP;
            end
         end
         MPC_ST_TRANSMIT: begin
            act_next = air_busy;
            if (!tx_req) begin
               state_next = MPC_ST_STANDBY;
               pm_next = `MPC_PM_STANDBY;
               act_next = 1'b0;
            end
         end
         MPC_ST_RECEIVE: begin
            act_next = air_busy;
            if (!rx_req) begin
               state_next = MPC_ST_STANDBY;
               pm_next = `MPC_PM_STANDBY;
               act_next = 1'b0;
            end
         end
         MPC_ST_SLEEP: begin
            act_next = 1'b0;
            if (tx_req && rx_req) begin
               state_next = MPC_ST_WAKE;
               cnt_next = `MPC_CNT_ZERO;
               act_next = 1'b1;
            end
         end
         MPC_ST_WAKE: begin
            // Clock source restart time; flag drops when standby reached
            if (cnt_done(cnt_reg, WAKE_N)) begin
               state_next = MPC_ST_STANDBY;
               pm_next = `MPC_PM_STANDBY;
               cnt_next = `MPC_CNT_ZERO;
               act_next = 1'b0;
            end else begin
               cnt_next = cnt_reg + `MPC_CNT_ONE;
            end
         end
         default: begin
            state_next = MPC_ST_RESET;
            cnt_next = `MPC_CNT_ZERO;
            pm_next = `MPC_PM_RESET;
            act_next = 1'b0;
         end
      endcase
      // Link reset overrides every state
      if (rst_req) begin
         state_next = MPC_ST_RESET;
         cnt_next = `MPC_CNT_ZERO;
         pm_next = `MPC_PM_RESET;
         act_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= MPC_ST_RESET;
         cnt_reg <= `MPC_CNT_ZERO;
         pm_reg <= `MPC_PM_RESET;
         act_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pm_reg <= pm_next;
         act_reg <= act_next;
      end
   end

   assign air_activity_flag = act_reg;
   assign tx_active = (state_reg == MPC_ST_TRANSMIT);
   assign rx_active = (state_reg == MPC_ST_RECEIVE);
   assign data_bus_tx_mode = (state_reg == MPC_ST_TRANSMIT);
   assign data_bus_rx_mode = (state_reg == MPC_ST_RECEIVE);
   // Mode field leaves only on the management view
   assign power_mode_field = pm_reg;
   assign phy_state = state_reg;

   reset_clears_a: assert property (@(posedge core_clk) disable iff (srst)
      rst_req |=> state_reg == MPC_ST_RESET && cnt_reg == `MPC_CNT_ZERO && pm_reg == `MPC_PM_RESET)
      else $error("link reset did not clear the state");

   standby_entry_a: assert property (@(posedge core_clk) disable iff (srst)
      state_reg == MPC_ST_RESET && !rst_req && cnt_done(cnt_reg, RESET_N)
      |=> state_reg == MPC_ST_STANDBY && pm_reg == `MPC_PM_STANDBY)
      else $error("standby not entered after reset work");

   reset_work_a: assert property (@(posedge core_clk) disable iff (srst || rst_req)
      $fell(rst_req) |-> state_reg == MPC_ST_RESET [*8])
      else $error("reset work finished too early");

   tx_entry_a: assert property (@(posedge core_clk) disable iff (srst)
      state_reg == MPC_ST_STANDBY && tx_req && !rx_req && !rst_req |=> tx_active && data_bus_tx_mode)
      else $error("transmit not entered on transmit enable");

   rx_entry_a: assert property (@(posedge core_clk) disable iff (srst)
      state_reg == MPC_ST_STANDBY && rx_req && !tx_req && !rst_req |=> rx_active && data_bus_rx_mode)
      else $error("receive not entered on receive enable");

   wake_seq_a: assert property (@(posedge core_clk) disable iff (srst || rst_req)
      state_reg == MPC_ST_SLEEP && tx_req && rx_req
      |=> air_activity_flag ##[1:WAKE_N] state_reg == MPC_ST_STANDBY)
      else $error("sleep exit did not reach standby");

   enables_ignored_a: assert property (@(posedge core_clk) disable iff (srst)
      state_reg == MPC_ST_RESET && (tx_req || rx_req) && !cnt_done(cnt_reg, RESET_N)
      |=> state_reg == MPC_ST_RESET && !tx_active && !rx_active)
      else $error("enable acted on before standby");

   activity_reset_a: assert property (@(posedge core_clk) disable iff (srst)
      state_reg == MPC_ST_RESET && !rst_req && !cnt_done(cnt_reg, RESET_N) |=> air_activity_flag)
      else $error("activity flag low during reset work");

   status_code_a: assert property (@(posedge core_clk) disable iff (srst)
      tx_active |-> power_mode_field == `MPC_PM_TRANSMIT && !rx_active)
      else $error("transmit status and mode field disagree");

   tx_path_c: cover property (@(posedge core_clk) disable iff (srst) tx_active ##1 !tx_active);
   rx_path_c: cover property (@(posedge core_clk) disable iff (srst) rx_active ##1 !rx_active);
   wake_path_c: cover property (@(posedge core_clk) disable iff (srst)
      state_reg == MPC_ST_WAKE ##1 state_reg == MPC_ST_STANDBY);
   reset_exit_c: cover property (@(posedge core_clk) disable iff (srst)
      state_reg == MPC_ST_RESET ##1 state_reg == MPC_ST_STANDBY);
endmodule

`default_nettype wire

// file: rtl/mpc_consts.svh
// Constants for the PHY control state block: codes, widths, timing.
// Assumes a 125 MHz core clock; included by the package, mpc_ctrl, mpc_sync and the bench.
`ifndef MPC_CONSTS_SVH
`define MPC_CONSTS_SVH

`define MPC_CLK_PERIOD_NS 8
`define MPC_RESET_WORK_NS 1000
`define MPC_WAKE_WORK_NS 200
`define MPC_RESET_WORK_CYC ((`MPC_RESET_WORK_NS + `MPC_CLK_PERIOD_NS - 1) / `MPC_CLK_PERIOD_NS)
`define MPC_WAKE_WORK_CYC ((`MPC_WAKE_WORK_NS + `MPC_CLK_PERIOD_NS - 1) / `MPC_CLK_PERIOD_NS)
`define MPC_CNT_W 8
`define MPC_CNT_ZERO 8'h00
`define MPC_CNT_ONE 8'h01

`define MPC_PM_W 3
`define MPC_PM_RESET 3'h0
`define MPC_PM_STANDBY 3'h1
`define MPC_PM_TRANSMIT 3'h2
`define MPC_PM_RECEIVE 3'h3
`define MPC_PM_SLEEP 3'h4

`define MPC_DATA_W 8
`define MPC_SYNC_W 3
`define MPC_SYNC_LRST 0
`define MPC_SYNC_TXEN 1
`define MPC_SYNC_RXEN 2
`define MPC_SYNC_RST_VAL 3'h0

`endif

// file: rtl/mpc_pkg.sv
// Types shared by the PHY control state block.
// Assumes mpc_consts.svh is on the include path.
`include "mpc_consts.svh"

package mpc_pkg;
   typedef enum logic [5:0] {
      MPC_ST_RESET = 6'h01,
      MPC_ST_STANDBY = 6'h02,
      MPC_ST_TRANSMIT = 6'h04,
      MPC_ST_RECEIVE = 6'h08,
      MPC_ST_SLEEP = 6'h10,
      MPC_ST_WAKE = 6'h20
   } mpc_state_type;

   typedef logic [`MPC_PM_W-1:0] mpc_pm_type;
   typedef logic [`MPC_CNT_W-1:0] mpc_cnt_type;
   typedef logic [`MPC_SYNC_W-1:0] mpc_sync_type;
endpackage

// file: rtl/mpc_sync_if.sv
// Carrier between the control core and its pin synchroniser.
// Assumes both ends sit on core_clk.
`timescale 1ns/1ns
`default_nettype none

interface mpc_sync_if;
   mpc_pkg::mpc_sync_type raw;
   mpc_pkg::mpc_sync_type synced;
   modport sync (input raw, output synced);
   modport user (output raw, input synced);
endinterface

`default_nettype wire

// file: rtl/mpc_sync.sv
// Two-flop synchroniser for the asynchronous link control pins.
// Assumes raw pins may change at any time relative to core_clk.
`timescale 1ns/1ns
`default_nettype none
`include "mpc_consts.svh"

module mpc_sync (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Pin side and synchronised side
   mpc_sync_if.sync sif
);
   import mpc_pkg::*;

   mpc_sync_type meta_reg;
   mpc_sync_type meta_next;
   mpc_sync_type stable_reg;
   mpc_sync_type stable_next;

   // Reset value reads as link reset held and both enables low
   always_comb begin
      meta_next = sif.raw;
      stable_next = meta_reg;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_reg <= `MPC_SYNC_RST_VAL;
         stable_reg <= `MPC_SYNC_RST_VAL;
      end else begin
         meta_reg <= meta_next;
         stable_reg <= stable_next;
      end
   end

   assign sif.synced = stable_reg;

   sync_latency_a: assert property (@(posedge core_clk) disable iff (srst)
      !$past(srst, 2) |-> sif.synced == $past(sif.raw, 2))
      else $error("synchroniser output is not the input two cycles late");
endmodule

`default_nettype wire

// file: dv/mpc_mac_model.sv
// Behavioural model of the access controller driving the PHY control pins.
// Assumes the bench calls drive(); its own clock has every edge on a core_clk falling edge.
`timescale 1ns/1ns
`default_nettype none

module mpc_mac_model (
   // Control group towards the PHY
   output logic link_reset_n,
   output logic tx_en,
   output logic rx_en
);
   logic mclk = 1'b0;
   logic mclk_run = 1'b1;

   // Interface clock halts in sleep, so nothing can be timed to it there
   always #32 mclk <= mclk_run ? ~mclk : mclk;

   initial begin
      link_reset_n = 1'b1;
      tx_en = 1'b0;
      rx_en = 1'b0;
   end

   // Pins change on own clock edge, or at an odd phase once stopped
   task automatic drive(input logic rst_n, input logic tx, input logic rx, input logic unclocked);
      if (unclocked) begin
         mclk_run = 1'b0;
         #13;
      end else begin
         mclk_run = 1'b1;
         @(posedge mclk);
      end
      link_reset_n <= rst_n;
      tx_en <= tx;
      rx_en <= rx;
   endtask
endmodule

`default_nettype wire

// file: dv/tb_mpc_ctrl.sv
// Self-checking bench for the PHY control state block.
// Assumes mpc_pkg, mpc_consts.svh and the partner model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "mpc_consts.svh"

module tb_mpc_ctrl;
   import mpc_pkg::*;
   logic core_clk, srst, sleep_req, air_busy;
   logic link_reset_n, tx_en, rx_en;
   logic air_activity_flag, tx_active, rx_active, data_bus_tx_mode, data_bus_rx_mode;
   mpc_pm_type power_mode_field;
   mpc_state_type phy_state;
   int error_cnt = 0;
   int n_compared = 0;

   mpc_mac_model u_mpc_mac_model (.link_reset_n(link_reset_n), .tx_en(tx_en), .rx_en(rx_en));
   mpc_ctrl u_mpc_ctrl (.core_clk(core_clk), .srst(srst), .link_reset_n(link_reset_n),
      .tx_en(tx_en), .rx_en(rx_en), .sleep_req(sleep_req), .air_busy(air_busy),
      .air_activity_flag(air_activity_flag), .tx_active(tx_active), .rx_active(rx_active),
      .data_bus_tx_mode(data_bus_tx_mode), .data_bus_rx_mode(data_bus_rx_mode),
      .power_mode_field(power_mode_field), .phy_state(phy_state));

   always #4 core_clk = ~core_clk;

   task automatic summarize;
      if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Outputs are read on the falling edge, clear of the update edge
   task automatic wait_st(input mpc_state_type st, input int lim, output int n);
      n = 0;
      while (phy_state !== st && n < lim) begin
         @(negedge core_clk);
         n++;
      end
   endtask

   task automatic t_reset;
      int n;
      @(negedge core_clk);
      check(8'(phy_state), 8'(MPC_ST_RESET));
      check(8'(power_mode_field), 8'(`MPC_PM_RESET));
      u_mpc_mac_model.drive(1'b1, 1'b1, 1'b0, 1'b0);
      repeat (60) @(negedge core_clk);
      check(8'(phy_state), 8'(MPC_ST_RESET));
      check(8'(air_activity_flag), 8'h01);
      u_mpc_mac_model.drive(1'b1, 1'b0, 1'b0, 1'b0);
      wait_st(MPC_ST_STANDBY, 200, n);
      check(8'(phy_state), 8'(MPC_ST_STANDBY));
      check(8'(power_mode_field), 8'(`MPC_PM_STANDBY));
      check(8'(air_activity_flag), 8'h00);
   endtask

   // One direction; the other enable is raised meanwhile and must be ignored
   task automatic t_dir(input logic rx);
      int n;
      u_mpc_mac_model.drive(1'b1, ~rx, rx, 1'b0);
      @(posedge core_clk);
      air_busy <= 1'b1;
      wait_st(rx ? MPC_ST_RECEIVE : MPC_ST_TRANSMIT, 6, n);
      check(8'(phy_state), 8'(rx ? MPC_ST_RECEIVE : MPC_ST_TRANSMIT));
      check(8'(power_mode_field), 8'(rx ? `MPC_PM_RECEIVE : `MPC_PM_TRANSMIT));
      check(8'({tx_active, rx_active}), 8'({~rx, rx}));
      check(8'({data_bus_tx_mode, data_bus_rx_mode}), 8'({~rx, rx}));
      u_mpc_mac_model.drive(1'b1, 1'b1, 1'b1, 1'b0);
      repeat (8) @(negedge core_clk);
      check(8'(phy_state), 8'(rx ? MPC_ST_RECEIVE : MPC_ST_TRANSMIT));
      check(8'(air_activity_flag), 8'h01);
      // Flag must follow the air status down while the direction holds
      @(posedge core_clk);
      air_busy <= 1'b0;
      repeat (2) @(negedge core_clk);
      check(8'(air_activity_flag), 8'h00);
      check(8'(phy_state), 8'(rx ? MPC_ST_RECEIVE : MPC_ST_TRANSMIT));
      u_mpc_mac_model.drive(1'b1, 1'b0, 1'b0, 1'b0);
      wait_st(MPC_ST_STANDBY, 6, n);
      check(8'(power_mode_field), 8'(`MPC_PM_STANDBY));
      check(8'({tx_active, rx_active, air_activity_flag}), 8'h00);
   endtask

   task automatic t_sleep;
      int n;
      @(posedge core_clk);
      sleep_req <= 1'b1;
      wait_st(MPC_ST_SLEEP, 4, n);
      check(8'(power_mode_field), 8'(`MPC_PM_SLEEP));
      @(posedge core_clk);
      sleep_req <= 1'b0;
      u_mpc_mac_model.drive(1'b1, 1'b1, 1'b1, 1'b1);
      wait_st(MPC_ST_WAKE, 6, n);
      check(8'(phy_state), 8'(MPC_ST_WAKE));
      check(8'(air_activity_flag), 8'h01);
      wait_st(MPC_ST_STANDBY, 40, n);
      check(8'(n >= 23 && n <= 27), 8'h01);
      check(8'(power_mode_field), 8'(`MPC_PM_STANDBY));
      repeat (10) @(negedge core_clk);
      check(8'(phy_state), 8'(MPC_ST_STANDBY));
      u_mpc_mac_model.drive(1'b1, 1'b0, 1'b0, 1'b0);
      repeat (6) @(negedge core_clk);
   endtask

   // Link reset arrives in mid-transmit on a MAC clock edge, which always falls on a core_clk falling edge
   task automatic t_lrst;
      int n;
      u_mpc_mac_model.drive(1'b1, 1'b1, 1'b0, 1'b0);
      wait_st(MPC_ST_TRANSMIT, 6, n);
      u_mpc_mac_model.drive(1'b0, 1'b1, 1'b0, 1'b0);
      wait_st(MPC_ST_RESET, 6, n);
      check(8'(phy_state), 8'(MPC_ST_RESET));
      check(8'({power_mode_field, tx_active, air_activity_flag}), 8'h00);
      u_mpc_mac_model.drive(1'b0, 1'b0, 1'b0, 1'b0);
      repeat (20) @(negedge core_clk);
      check(8'(phy_state), 8'(MPC_ST_RESET));
      u_mpc_mac_model.drive(1'b1, 1'b0, 1'b0, 1'b0);
      wait_st(MPC_ST_STANDBY, 200, n);
      check(8'(n >= 124 && n <= 132), 8'h01);
      check(8'(power_mode_field), 8'(`MPC_PM_STANDBY));
   endtask

   initial begin
      core_clk = 1'b0;
      srst = 1'b1;
      sleep_req = 1'b0;
      air_busy = 1'b0;
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      t_reset();
      t_dir(1'b0);
      t_dir(1'b1);
      t_sleep();
      t_lrst();
      summarize();
   end

   initial begin
      #40000;
      error_cnt++;
      summarize();
   end
endmodule

`default_nettype wire
